// >>> src/rss_pkg.sv
/*
 * shared constants for the reset and start-up sequencer: address map,
 * pending flag positions, eeprom link timing and sequencer states.
 * assumes a single 125 MHz clock and a byte-wide internal memory.
 */
package rss_pkg;
    // clock and eeprom serial link timing
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned EE_SCK_HZ = 5_000_000;
    // half period of the eeprom clock, rounded up so the rate is never exceeded
    localparam int unsigned EE_HALF = (CLK_HZ + 2 * EE_SCK_HZ - 1) /
        (2 * EE_SCK_HZ);
    localparam logic [7:0] EE_CMD_READ = 8'h03;
    localparam int unsigned EE_FRAME_BITS = 32;

    // address map
    localparam int AW = 16;
    localparam int unsigned MEM_DEPTH = 33024;
    localparam logic [15:0] ADDR_FIRST = 16'h0000;
    localparam logic [15:0] DATA_END = 16'h33FF;
    localparam logic [15:0] TABLE_END = 16'h7FFF;
    localparam logic [15:0] REG_END = 16'h807F;
    localparam logic [15:0] MCR_ADDR = 16'h8000;
    localparam logic [15:0] PIR_ADDR = 16'h800A;
    localparam logic [15:0] FAIL_LO_ADDR = 16'h8073;
    localparam logic [15:0] FAIL_HI_ADDR = 16'h8074;
    localparam logic [15:0] CHK_ADDR = 16'h8080;

    // fields
    localparam int MCR_TXEN_BIT = 0;
    localparam int PIR_COPY_BIT = 7;
    localparam int PIR_AUTO_BIT = 6;
    localparam int PIR_CHK_BIT = 5;
    localparam int PIR_RAM_BIT = 4;
    localparam logic [7:0] REG_DEFAULT = 8'h00;

    // modes
    localparam logic [2:0] MODE_LAST_FULL = 3'h3;
    localparam logic [2:0] MODE_LOAD_ONLY = 3'h4;
    localparam logic [2:0] MODE_DATA_LOAD = 3'h5;
    localparam logic [2:0] MODE_TEST_A = 3'h2;
    localparam logic [2:0] MODE_TEST_B = 3'h3;

    // sequencer states, gray along the start-up path
    typedef enum logic [3:0] {
        ST_RST = 4'h0,
        ST_TW = 4'h1,
        ST_TR = 4'h3,
        ST_TC = 4'h2,
        ST_TV = 4'h6,
        ST_CLR = 4'h7,
        ST_LD = 4'h5,
        ST_VF = 4'h4,
        ST_CK = 4'hC,
        ST_IDLE = 4'hD,
        ST_ACT = 4'hF,
        ST_SAFE = 4'hE
    } rss_state_t;
endpackage

// >>> src/rss_mem.sv
/*
 * byte-wide single-port memory holding tables, data and registers.
 * read data come from a register one cycle after the address;
 * a write returns the old contents, one cycle later like a read.
 */
module rss_mem (
    // clock
    input wire logic clk,
    // access port
    input wire logic we,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    logic [7:0] mem [rss_pkg::MEM_DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule // rss_mem

// >>> src/rss_ee_rd.sv
/*
 * eeprom serial reader: one byte per request, read command plus 16-bit
 * address then eight data bits, spi mode 0, clock made by a divider.
 * assumes req only while idle and the address stable on the req cycle.
 */
module rss_ee_rd (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // request side
    input wire logic req,
    input wire logic [15:0] addr,
    output logic done,
    output logic [7:0] data,
    // eeprom pins
    output logic ee_sck,
    output logic ee_cs_n,
    output logic ee_mosi,
    input wire logic ee_miso
);
    typedef struct packed {
        logic busy;
        logic cs_n;
        logic sck;
        logic mosi;
        logic [5:0] cnt;
        logic [7:0] div;
        logic [31:0] tx;
        logic [7:0] rx;
        logic done;
        logic [7:0] data;
        logic miso1;
        logic miso2;
    } rss_ee_st_t;

    rss_ee_st_t r;
    rss_ee_st_t next_r;

    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        next_r.miso1 = ee_miso;
        next_r.miso2 = r.miso1;
        if (!r.busy) begin
            if (req) begin
                next_r.busy = 1'b1;
                next_r.cs_n = 1'b0;
                next_r.sck = 1'b0;
                next_r.cnt = 6'h00;
                next_r.div = 8'h00;
                next_r.tx = {rss_pkg::EE_CMD_READ, addr, 8'h00};
                next_r.mosi = rss_pkg::EE_CMD_READ[7];
            end
        end else if (r.div == 8'(rss_pkg::EE_HALF - 1)) begin
            next_r.div = 8'h00;
            if (!r.sck) begin
                // sample on the rising edge; only the last eight bits survive
                next_r.sck = 1'b1;
                next_r.rx = {r.rx[6:0], r.miso2};
                next_r.cnt = r.cnt + 6'h01;
            end else begin
                next_r.sck = 1'b0;
                if (r.cnt == 6'(rss_pkg::EE_FRAME_BITS)) begin
                    next_r.busy = 1'b0;
                    next_r.cs_n = 1'b1;
                    next_r.done = 1'b1;
                    next_r.data = r.rx;
                end else begin
                    next_r.tx = {r.tx[30:0], 1'b0};
                    next_r.mosi = r.tx[30];
                end
            end
        end else begin
            next_r.div = r.div + 8'h01;
        end
        if (rst) begin
            next_r = '0;
            next_r.cs_n = 1'b1;
            next_r.miso1 = ee_miso;
            next_r.miso2 = r.miso1;
        end
    end

    always_ff @(posedge clk) begin
        r <= next_r;
    end

    assign done = r.done;
    assign data = r.data;
    assign ee_sck = r.sck;
    assign ee_cs_n = r.cs_n;
    assign ee_mosi = r.mosi;
endmodule // rss_ee_rd

// >>> src/rss_init.sv
/*
 * reset and start-up sequencer: mode capture at reset release, ram test,
 * memory and register clearing, eeprom auto-load with compare and
 * checksum, then idle, safe or active; also the host memory port.
 * assumes an external spi front end turns host instructions into
 * single-byte requests on the HOST_ port, on REF_CLK.
 */
// Operation
// - reset high stops everything at once and holds ready low
// - mode pins captured only at reset release, picking one of six modes
// - clean finish raises ready and enters idle, no bus traffic there
// - rising edge of run moves idle to active, starting bus processing
// - modes 2 and 3 write incrementing pattern over ram, then verify it
// - then each location rewritten with its complement and verified
// - ram test failure sets ram-fail flag, interrupt, safe until reset
// - modes 0,1,2,3,5 zero data area 0x0000 to 0x33FF
// - modes 0 to 3 also zero tables and default registers to 0x807F
// - register default value is zero unless stated otherwise
// - auto-load copies eeprom image into memory and registers
// - auto-load verified by byte compare and image checksum
// - compare mismatch sets flag, interrupt, fail address, enters safe
// - checksum failure sets flag, interrupt, enters safe
// - fault flags are never masked from the master interrupt
// - transmission allowed only while run and global transmit enable high
// - pending register bits 7,6,5,4: copy, compare, checksum, ram fail
// - master interrupt held while any pending bit is set
module rss_init (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST,
    // device pins
    input wire logic [2:0] INIT_SELECT_PINS,
    input wire logic RUN,
    output logic READY,
    output logic MASTER_IRQ_OUT,
    output logic SAFE_STATE,
    output logic BUS_ACTIVE,
    output logic TX_ALLOW,
    // eeprom link
    output logic EE_SCK,
    output logic EE_CS_N,
    output logic EE_MOSI,
    input wire logic EE_MISO,
    // host memory port
    input wire logic HOST_REQ,
    input wire logic HOST_WE,
    input wire logic [15:0] HOST_ADDR,
    input wire logic [7:0] HOST_WDATA,
    output logic HOST_ACK,
    output logic [7:0] HOST_RDATA
);
    typedef struct packed {
        rss_pkg::rss_state_t state;
        logic [15:0] addr;
        logic sub;
        logic [2:0] mode;
        logic [2:0] mode_s1;
        logic [2:0] mode_s2;
        logic run_s1;
        logic run_s2;
        logic run_s3;
        logic [7:0] sum;
        logic [7:4] pend;
        logic [15:0] fail_addr;
        logic txen;
        logic ee_req;
        logic ready;
        logic irq;
        logic safe;
        logic active;
        logic tx_allow;
        logic host_busy;
        logic [15:0] host_addr;
        logic host_ack;
        logic [7:0] host_rdata;
    } rss_st_t;

    rss_st_t r;
    rss_st_t next_r;

    logic mem_we;
    logic [15:0] mem_addr;
    logic [7:0] mem_wdata;
    logic [7:0] mem_rdata;
    logic [15:0] ee_addr;
    logic ee_done;
    logic [7:0] ee_data;

    function automatic logic mode_test(input logic [2:0] m);
        mode_test = (m == rss_pkg::MODE_TEST_A) || (m == rss_pkg::MODE_TEST_B);
    endfunction

    function automatic logic mode_clr_all(input logic [2:0] m);
        mode_clr_all = (m <= rss_pkg::MODE_LAST_FULL);
    endfunction

    function automatic logic mode_clr_data(input logic [2:0] m);
        mode_clr_data = mode_clr_all(m) || (m == rss_pkg::MODE_DATA_LOAD);
    endfunction

    function automatic logic mode_load(input logic [2:0] m);
        mode_load = m[0] || (m == rss_pkg::MODE_LOAD_ONLY);
    endfunction

    // step that follows the ram test or the clearing, in fixed order
    function automatic rss_pkg::rss_state_t after_clr(input logic [2:0] m);
        after_clr = mode_load(m) ? rss_pkg::ST_LD : rss_pkg::ST_IDLE;
    endfunction

    function automatic rss_pkg::rss_state_t after_test(input logic [2:0] m);
        after_test = mode_clr_data(m) ? rss_pkg::ST_CLR : after_clr(m);
    endfunction

    // host may not overwrite status kept in flops, nor reach past the map
    function automatic logic host_writable(input logic [15:0] a);
        host_writable = (a <= rss_pkg::REG_END) && (a != rss_pkg::PIR_ADDR) &&
            (a != rss_pkg::FAIL_LO_ADDR) && (a != rss_pkg::FAIL_HI_ADDR);
    endfunction

    always_comb begin
        next_r = r;
        next_r.ee_req = 1'b0;
        next_r.host_ack = 1'b0;
        next_r.mode_s1 = INIT_SELECT_PINS;
        next_r.mode_s2 = r.mode_s1;
        next_r.run_s1 = RUN;
        next_r.run_s2 = r.run_s1;
        next_r.run_s3 = r.run_s2;
        mem_we = 1'b0;
        mem_addr = r.addr;
        mem_wdata = 8'h00;
        ee_addr = (r.state == rss_pkg::ST_CK) ? rss_pkg::CHK_ADDR : r.addr;

        case (r.state)
            rss_pkg::ST_RST: begin
                // first cycle after reset release: the one and only sample
                next_r.mode = r.mode_s2;
                next_r.addr = rss_pkg::ADDR_FIRST;
                next_r.sub = 1'b0;
                next_r.sum = 8'h00;
                if (mode_test(r.mode_s2)) begin
                    next_r.state = rss_pkg::ST_TW;
                end else begin
                    next_r.state = after_test(r.mode_s2);
                end
            end
            rss_pkg::ST_TW: begin
                mem_we = 1'b1;
                mem_wdata = r.addr[7:0];
                next_r.addr = r.addr + 16'h0001;
                if (r.addr == rss_pkg::TABLE_END) begin
                    next_r.addr = rss_pkg::ADDR_FIRST;
                    next_r.state = rss_pkg::ST_TR;
                end
            end
            rss_pkg::ST_TR, rss_pkg::ST_TV: begin
                next_r.sub = ~r.sub;
                if (r.sub) begin
                    if (mem_rdata != ((r.state == rss_pkg::ST_TV) ?
                            ~r.addr[7:0] : r.addr[7:0])) begin
                        next_r.pend[rss_pkg::PIR_RAM_BIT] = 1'b1;
                        next_r.state = rss_pkg::ST_SAFE;
                    end else if (r.addr == rss_pkg::TABLE_END) begin
                        next_r.addr = rss_pkg::ADDR_FIRST;
                        next_r.state = (r.state == rss_pkg::ST_TR) ?
                            rss_pkg::ST_TC : after_test(r.mode);
                    end else begin
                        next_r.addr = r.addr + 16'h0001;
                    end
                end
            end
            rss_pkg::ST_TC: begin
                next_r.sub = ~r.sub;
                if (r.sub) begin
                    mem_we = 1'b1;
                    mem_wdata = ~mem_rdata;
                    next_r.addr = r.addr + 16'h0001;
                    if (r.addr == rss_pkg::TABLE_END) begin
                        next_r.addr = rss_pkg::ADDR_FIRST;
                        next_r.state = rss_pkg::ST_TV;
                    end
                end
            end
            rss_pkg::ST_CLR: begin
                mem_we = 1'b1;
                mem_wdata = rss_pkg::REG_DEFAULT;
                next_r.addr = r.addr + 16'h0001;
                if (r.addr == rss_pkg::MCR_ADDR) begin
                    next_r.txen = 1'b0;
                end
                if ((r.addr == rss_pkg::REG_END) || ((r.addr ==
                        rss_pkg::DATA_END) && !mode_clr_all(r.mode))) begin
                    next_r.addr = rss_pkg::ADDR_FIRST;
                    next_r.state = after_clr(r.mode);
                end
            end
            rss_pkg::ST_LD: begin
                if (!r.sub) begin
                    next_r.ee_req = 1'b1;
                    next_r.sub = 1'b1;
                end else if (ee_done) begin
                    mem_we = 1'b1;
                    mem_wdata = ee_data;
                    next_r.sum = r.sum + ee_data;
                    next_r.sub = 1'b0;
                    next_r.addr = r.addr + 16'h0001;
                    if (r.addr == rss_pkg::MCR_ADDR) begin
                        next_r.txen = ee_data[rss_pkg::MCR_TXEN_BIT];
                    end
                    if (r.addr == rss_pkg::REG_END) begin
                        next_r.addr = rss_pkg::ADDR_FIRST;
                        next_r.state = rss_pkg::ST_VF;
                    end
                end
            end
            rss_pkg::ST_VF: begin
                if (!r.sub) begin
                    next_r.ee_req = 1'b1;
                    next_r.sub = 1'b1;
                end else if (ee_done) begin
                    next_r.sub = 1'b0;
                    if (ee_data != mem_rdata) begin
                        next_r.pend[rss_pkg::PIR_AUTO_BIT] = 1'b1;
                        next_r.fail_addr = r.addr;
                        next_r.state = rss_pkg::ST_SAFE;
                    end else if (r.addr == rss_pkg::REG_END) begin
                        next_r.state = rss_pkg::ST_CK;
                    end else begin
                        next_r.addr = r.addr + 16'h0001;
                    end
                end
            end
            rss_pkg::ST_CK: begin
                if (!r.sub) begin
                    next_r.ee_req = 1'b1;
                    next_r.sub = 1'b1;
                end else if (ee_done) begin
                    next_r.sub = 1'b0;
                    // image plus its checksum byte must sum to zero
                    if ((r.sum + ee_data) != 8'h00) begin
                        next_r.pend[rss_pkg::PIR_CHK_BIT] = 1'b1;
                        next_r.state = rss_pkg::ST_SAFE;
                    end else begin
                        next_r.state = rss_pkg::ST_IDLE;
                    end
                end
            end
            rss_pkg::ST_IDLE: begin
                if (r.run_s2 && !r.run_s3) begin
                    next_r.state = rss_pkg::ST_ACT;
                end
            end
            rss_pkg::ST_ACT, rss_pkg::ST_SAFE: begin
                // safe is left only through reset
            end
            default: begin
                next_r.state = rss_pkg::ST_SAFE;
            end
        endcase

        // host port, open once start-up is over
        if ((r.state == rss_pkg::ST_IDLE) || (r.state == rss_pkg::ST_ACT) ||
                (r.state == rss_pkg::ST_SAFE)) begin
            if (r.host_busy) begin
                next_r.host_busy = 1'b0;
                next_r.host_ack = 1'b1;
                if (r.host_addr == rss_pkg::PIR_ADDR) begin
                    next_r.host_rdata = {r.pend, 4'h0};
                end else if (r.host_addr == rss_pkg::FAIL_LO_ADDR) begin
                    next_r.host_rdata = r.fail_addr[7:0];
                end else if (r.host_addr == rss_pkg::FAIL_HI_ADDR) begin
                    next_r.host_rdata = r.fail_addr[15:8];
                end else if (r.host_addr > rss_pkg::REG_END) begin
                    next_r.host_rdata = 8'h00;
                end else begin
                    next_r.host_rdata = mem_rdata;
                end
            end else if (HOST_REQ) begin
                next_r.host_busy = 1'b1;
                next_r.host_addr = HOST_ADDR;
                mem_addr = HOST_ADDR;
                mem_wdata = HOST_WDATA;
                mem_we = HOST_WE && host_writable(HOST_ADDR);
                if (mem_we && (HOST_ADDR == rss_pkg::MCR_ADDR)) begin
                    next_r.txen = HOST_WDATA[rss_pkg::MCR_TXEN_BIT];
                end
            end
        end

        // fault flags have no mask: any set flag holds the interrupt
        next_r.irq = |next_r.pend;
        next_r.ready = (next_r.state == rss_pkg::ST_IDLE) ||
            (next_r.state == rss_pkg::ST_ACT);
        next_r.safe = (next_r.state == rss_pkg::ST_SAFE);
        next_r.active = (next_r.state == rss_pkg::ST_ACT);
        next_r.tx_allow = next_r.active && r.run_s2 &&
            next_r.txen;

        if (RST) begin
            // halt at once; the pin synchronisers keep running
            next_r = '0;
            next_r.state = rss_pkg::ST_RST;
            next_r.mode_s1 = INIT_SELECT_PINS;
            next_r.mode_s2 = r.mode_s1;
            next_r.run_s1 = RUN;
            next_r.run_s2 = r.run_s1;
            next_r.run_s3 = r.run_s2;
            mem_we = 1'b0;
        end
    end

    always_ff @(posedge REF_CLK) begin
        r <= next_r;
    end

    rss_mem u_mem (
        .clk(REF_CLK),
        .we(mem_we),
        .addr(mem_addr),
        .wdata(mem_wdata),
        .rdata(mem_rdata)
    );

    rss_ee_rd u_ee (
        .clk(REF_CLK),
        .rst(RST),
        .req(r.ee_req),
        .addr(ee_addr),
        .done(ee_done),
        .data(ee_data),
        .ee_sck(EE_SCK),
        .ee_cs_n(EE_CS_N),
        .ee_mosi(EE_MOSI),
        .ee_miso(EE_MISO)
    );

    assign READY = r.ready;
    assign MASTER_IRQ_OUT = r.irq;
    assign SAFE_STATE = r.safe;
    assign BUS_ACTIVE = r.active;
    assign TX_ALLOW = r.tx_allow;
    assign HOST_ACK = r.host_ack;
    assign HOST_RDATA = r.host_rdata;
endmodule // rss_init

// >>> verification/rss_ee_model.sv
/*
 * serial eeprom model: read command, 16-bit address, one data byte out.
 * assumes spi mode 0 from the sequencer; data byte is address low ^ A5.
 */
module rss_ee_model (
    // eeprom pins
    input wire logic ee_sck,
    input wire logic ee_cs_n,
    input wire logic ee_mosi,
    output logic ee_miso,
    // observation
    output logic [31:0] last_frame,
    output int frames
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] sh;
    logic [7:0] dat;
    int n;
    initial begin
        ee_miso = 1'b0;
        sh = 32'h0;
        dat = 8'h0;
        n = 0;
        frames = 0;
        last_frame = 32'h0;
    end
    always @(posedge ee_sck) begin
        if (!ee_cs_n) begin
            sh = {sh[30:0], ee_mosi};
            n++;
        end
    end
    // data changes after the fall, well before the next rise
    always @(negedge ee_sck) begin
        if (!ee_cs_n && n == 24) dat = sh[7:0] ^ 8'hA5;
        if (!ee_cs_n && n >= 24 && n < 32) ee_miso <= dat[31 - n];
    end
    // released line does not hold its last value
    always @(posedge ee_cs_n) begin
        if (n == 32) begin
            last_frame = sh;
            frames++;
        end
        n = 0;
        ee_miso <= ~ee_miso;
    end
endmodule // rss_ee_model

// >>> verification/rss_init_assertions.sv
/*
 * checker for the start-up sequencer ports.
 * assumes one clock, REF_CLK, and synchronous reset RST.
 */
module rss_init_assertions (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST,
    // pins
    input wire logic RUN,
    input wire logic READY,
    input wire logic MASTER_IRQ_OUT,
    input wire logic SAFE_STATE,
    input wire logic BUS_ACTIVE,
    input wire logic TX_ALLOW,
    input wire logic EE_SCK,
    input wire logic EE_CS_N,
    input wire logic HOST_REQ,
    input wire logic HOST_ACK
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);
    sequence s_run_held;
        ($rose(RUN) && READY && !BUS_ACTIVE) ##1 RUN [*6];
    endsequence
    sequence s_frame_start;
        $fell(EE_CS_N);
    endsequence
    property p_rst_quiet;
        disable iff (1'b0) RST |=> !READY && !BUS_ACTIVE && !TX_ALLOW &&
            !SAFE_STATE && EE_CS_N;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet)
        else $error("reset not quiet");
    property p_irq_hold;
        MASTER_IRQ_OUT |=> MASTER_IRQ_OUT;
    endproperty
    a_irq_hold: assert property (p_irq_hold)
        else $error("irq dropped");
    property p_safe_hold;
        SAFE_STATE |=> SAFE_STATE && !READY && !BUS_ACTIVE;
    endproperty
    a_safe_hold: assert property (p_safe_hold)
        else $error("safe left");
    property p_fault;
        $rose(MASTER_IRQ_OUT) |-> ##[0:2] SAFE_STATE;
    endproperty
    a_fault: assert property (p_fault)
        else $error("fault without safe");
    property p_run;
        s_run_held |=> BUS_ACTIVE;
    endproperty
    a_run: assert property (p_run)
        else $error("run edge ignored");
    property p_tx_cause;
        TX_ALLOW |-> BUS_ACTIVE && READY;
    endproperty
    a_tx_cause: assert property (p_tx_cause)
        else $error("tx outside active");
    property p_run_low;
        !RUN [*5] |-> !TX_ALLOW;
    endproperty
    a_run_low: assert property (p_run_low)
        else $error("tx without run");
    property p_ack;
        HOST_ACK |-> $past(HOST_REQ, 2) && !$past(HOST_ACK);
    endproperty
    a_ack: assert property (p_ack)
        else $error("stray ack");
    property p_ready_clean;
        $rose(READY) |-> !SAFE_STATE && !MASTER_IRQ_OUT && EE_CS_N;
    endproperty
    a_ready_clean: assert property (p_ready_clean)
        else $error("bad ready");
    property p_frame;
        s_frame_start |-> !EE_SCK && !READY && !SAFE_STATE;
    endproperty
    a_frame: assert property (p_frame)
        else $error("frame out of order");
endmodule // rss_init_assertions
bind rss_init rss_init_assertions u_chk (.REF_CLK(REF_CLK), .RST(RST),
    .RUN(RUN), .READY(READY), .MASTER_IRQ_OUT(MASTER_IRQ_OUT),
    .SAFE_STATE(SAFE_STATE), .BUS_ACTIVE(BUS_ACTIVE), .TX_ALLOW(TX_ALLOW),
    .EE_SCK(EE_SCK), .EE_CS_N(EE_CS_N), .HOST_REQ(HOST_REQ),
    .HOST_ACK(HOST_ACK));

// >>> verification/rss_init_bench.sv
/*
 * bench for the start-up sequencer: mode 0 clear, host access, run,
 * then mode 4 first eeprom frame and reset in mid-load.
 * assumes the eeprom model stands on the eeprom pins.
 */
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module rss_init_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, run, ready, irq, safe, bus_act, tx_allow;
    logic sck, cs_n, mosi, miso, req, we, ack;
    logic [2:0] pins;
    logic [15:0] addr;
    logic [7:0] wdata, rdata, e, m_exp;
    logic [31:0] frame;
    int frames, failures, total_checks, i;
    logic [7:0] exp_q[$];
    logic [15:0] a;
    rss_init dut (.REF_CLK(clk), .RST(rst), .INIT_SELECT_PINS(pins),
        .RUN(run), .READY(ready), .MASTER_IRQ_OUT(irq), .SAFE_STATE(safe),
        .BUS_ACTIVE(bus_act), .TX_ALLOW(tx_allow), .EE_SCK(sck),
        .EE_CS_N(cs_n), .EE_MOSI(mosi), .EE_MISO(miso), .HOST_REQ(req),
        .HOST_WE(we), .HOST_ADDR(addr), .HOST_WDATA(wdata), .HOST_ACK(ack),
        .HOST_RDATA(rdata));
    rss_ee_model ee (.ee_sck(sck), .ee_cs_n(cs_n), .ee_mosi(mosi),
        .ee_miso(miso), .last_frame(frame), .frames(frames));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task wrap_up;
        if (failures == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // one byte access; the old contents come back on a write too
    task host(input logic w, input logic [15:0] ad, input logic [7:0] d,
        input logic [7:0] ex);
        @(posedge clk);
        req <= 1'b1;
        we <= w;
        addr <= ad;
        wdata <= d;
        exp_q.push_back(ex);
        @(posedge clk);
        req <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    always @(posedge clk) begin
        if (ack === 1'b1) begin
            if (exp_q.size() == 0) `CHK(1'b1, 1'b0)
            else begin
                m_exp = exp_q.pop_front();
                `CHK(rdata, m_exp)
            end
        end
    end
    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        wrap_up();
    end
    initial begin
        void'($urandom(32'h8AD7));
        {rst, run, req, we, pins, addr, wdata} = {1'b1, 30'h0};
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        pins <= 3'h4;
        req <= 1'b1;
        we <= 1'b1;
        wdata <= 8'hFF;
        @(posedge clk);
        req <= 1'b0;
        for (i = 0; i < 40000 && ready !== 1'b1; i++) @(posedge clk);
        `CHK(ready, 1'b1)
        `CHK({safe, irq, bus_act}, 3'h0)
        `CHK(frames, 0)
        host(0, 16'h0000, 8'h0, 8'h0);
        host(0, 16'h33FF, 8'h0, 8'h0);
        host(0, 16'h3400, 8'h0, 8'h0);
        host(0, 16'h7FFF, 8'h0, 8'h0);
        host(0, 16'h807F, 8'h0, 8'h0);
        host(0, 16'h800A, 8'h0, 8'h0);
        repeat (6) begin
            a = 16'($urandom % 32'h8000);
            e = 8'($urandom);
            host(1, a, e, 8'h0);
            host(0, a, 8'h0, e);
        end
        host(1, 16'h8073, 8'h5A, 8'h0);
        host(0, 16'h8073, 8'h0, 8'h0);
        run <= 1'b1;
        repeat (10) @(posedge clk);
        `CHK({bus_act, tx_allow}, 2'b10)
        host(1, 16'h8000, 8'h01, 8'h0);
        repeat (4) @(posedge clk);
        `CHK(tx_allow, 1'b1)
        run <= 1'b0;
        repeat (6) @(posedge clk);
        `CHK({bus_act, tx_allow}, 2'b10)
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        `CHK({ready, bus_act}, 2'b00)
        rst <= 1'b0;
        for (i = 0; i < 3000 && frames < 1; i++) @(posedge clk);
        `CHK(frame[31:8], 24'h030000)
        for (i = 0; i < 100 && cs_n !== 1'b0; i++) @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK({cs_n, ready}, 2'b10)
        wrap_up();
    end
endmodule // rss_init_bench
